// [rtl/lcd_instr_map.vh]
// constants for the mode and shift instruction decoder
`ifndef LCD_INSTR_MAP_VH
`define LCD_INSTR_MAP_VH
// instruction bit positions
`define ENT_DIR_BIT 1
`define ENT_FOLLOW_BIT 0
`define DISP_ON_BIT 2
`define DISP_CUR_BIT 1
`define DISP_BLINK_BIT 0
`define SHF_TARGET_BIT 3
`define SHF_DIR_BIT 2
`define FN_WIDTH_BIT 4
`define FN_LINES_BIT 3
`define FN_FONT_BIT 2
// reset values
`define ENT_DIR_RST 1'b1
`define ENT_FOLLOW_RST 1'b0
`define WIDTH_RST 1'b1
// address layout
`define LINE_LAST 7'h27
`define LINE2_BASE 7'h40
`define LINE2_LAST 7'h67
`define ONE_LINE_LAST 7'h4F
`define SHIFT_LAST 7'h27
// drive settings
`define DUTY_9 5'h09
`define DUTY_12 5'h0C
`define DUTY_17 5'h11
`define BIAS_4 3'h4
`define BIAS_5 3'h5
// execution time: 37 us at 100 MHz
`define EXEC_NS 37000
`define CLK_NS 10
`define EXEC_CYC (`EXEC_NS / `CLK_NS)
// last value of the busy down-counter, execution cycles less one
`define EXEC_LAST 13'hE73
`endif

// [rtl/lcd_sync2.v]
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module lcd_sync2
(
   input wire i_clk,
   input wire i_rst_n,
   input wire i_d,
   output reg o_q
);
   reg meta_q;
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_q <= 1'b0;
         o_q <= 1'b0;
      end
      else
      begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule // lcd_sync2
`default_nettype wire

// [rtl/lcd_busy_timer.v]
// busy timer covering one instruction execution
`timescale 1ns/1ps
`default_nettype none
`include "lcd_instr_map.vh"
module lcd_busy_timer
(
   input wire i_clk,
   input wire i_rst_n,
   input wire i_start,
   output reg o_busy
);
   localparam [12:0] LAST = `EXEC_LAST;
   reg [12:0] cnt_q;
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_q <= 13'h0000;
         o_busy <= 1'b0;
      end
      else if (i_start)
      begin
         cnt_q <= LAST;
         o_busy <= 1'b1;
      end
      else if (cnt_q != 13'h0000)
         cnt_q <= cnt_q - 13'h0001;
      else
         o_busy <= 1'b0;
   end
endmodule // lcd_busy_timer
`default_nettype wire

// [rtl/lcd_mode_shift_instructions.v]
// decoder and state for entry, display, shift and function instructions
`timescale 1ns/1ps
`default_nettype none
`include "lcd_instr_map.vh"
module lcd_mode_shift_instructions
(
   // clock and reset
   input wire i_clk,
   input wire i_reset_n,
   // host instruction strobe (from pins)
   input wire i_strobe,
   input wire i_register_select_high,
   input wire i_register_select_low,
   input wire i_read_not_write,
   input wire [7:0] i_data,
   input wire i_serial_mode,
   // ram access events from the data path (same clock)
   input wire i_ram_access,
   input wire i_ram_write,
   input wire [1:0] i_ram_target,
   input wire i_addr_load,
   input wire [6:0] i_addr_value,
   // state
   output reg o_busy_flag,
   output reg [6:0] o_addr_counter,
   output reg [6:0] o_shift_line1,
   output reg [6:0] o_shift_line2,
   output reg o_entry_dir,
   output reg o_entry_follow,
   output reg o_show_chars,
   output reg o_show_cursor,
   output reg o_show_blink,
   output reg o_bus_width_select,
   output reg o_two_lines,
   output reg o_big_font,
   output reg [4:0] o_duty,
   output reg [2:0] o_bias,
   output reg [4:0] o_commons,
   output reg o_function_done
);
   // ram targets
   localparam [1:0] TGT_CHAR = 2'h0;
   localparam [1:0] TGT_GLYPH = 2'h1;
   localparam [1:0] TGT_ARB = 2'h2;
   // ==================================================
   // reset release and pin synchronisers
   // reset enters asynchronously but leaves on the clock
   reg rst_a_q;
   reg rst_b_q;
   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rst_a_q <= 1'b0;
         rst_b_q <= 1'b0;
      end
      else
      begin
         rst_a_q <= 1'b1;
         rst_b_q <= rst_a_q;
      end
   end
   wire rst_n = rst_b_q;
   wire stb_s;
   wire rs1_s;
   wire rs0_s;
   wire rw_s;
   wire ser_s;
   wire [7:0] dat_s;
   lcd_sync2 u_sync_stb
   (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_d(i_strobe),
      .o_q(stb_s)
   );
   lcd_sync2 u_sync_rs1
   (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_d(i_register_select_high),
      .o_q(rs1_s)
   );
   lcd_sync2 u_sync_rs0
   (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_d(i_register_select_low),
      .o_q(rs0_s)
   );
   lcd_sync2 u_sync_rw
   (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_d(i_read_not_write),
      .o_q(rw_s)
   );
   lcd_sync2 u_sync_ser
   (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_d(i_serial_mode),
      .o_q(ser_s)
   );
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_dat
         lcd_sync2 u_sync_dat
         (
            .i_clk(i_clk),
            .i_rst_n(rst_n),
            .i_d(i_data[gi]),
            .o_q(dat_s[gi])
         );
      end
   endgenerate
   // ==================================================
   // strobe edge and decode
   reg stb_prev_q;
   always @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         stb_prev_q <= 1'b0;
      else
         stb_prev_q <= stb_s;
   end
   wire busy;
   // strobe and data pass the same two flops, so the byte is whole
   // on the cycle in which its strobe edge is seen
   wire stb_rise = stb_s & ~stb_prev_q;
   wire sel_instr = rs1_s & ~rs0_s & ~rw_s;
   // strobes while busy are dropped silently
   wire take = stb_rise & sel_instr & ~busy;
   // the highest set bit names the instruction
   wire is_fn = take & (dat_s[7:5] == 3'h1);
   wire is_shf = take & (dat_s[7:4] == 4'h1);
   wire is_disp = take & (dat_s[7:3] == 5'h01);
   wire is_ent = take & (dat_s[7:2] == 6'h01);
   wire start = is_fn | is_shf | is_disp | is_ent;
   lcd_busy_timer u_busy
   (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_start(start),
      .o_busy(busy)
   );
   // ==================================================
   // address step helpers
   function [6:0] step_char;
      input [6:0] a;
      input up;
      input two;
      begin
         // two-line mode runs 00h-27h, then 40h-67h, then back to 00h
         if (!two)
            step_char = up ? ((a >= `ONE_LINE_LAST) ? 7'h00 : a + 7'h01)
               : ((a == 7'h00) ? `ONE_LINE_LAST : a - 7'h01);
         else if (up)
            step_char = (a == `LINE_LAST) ? `LINE2_BASE
               : (a >= `LINE2_LAST) ? 7'h00 : a + 7'h01;
         else
            step_char = (a == `LINE2_BASE) ? `LINE_LAST
               : (a == 7'h00) ? `LINE2_LAST : a - 7'h01;
      end
   endfunction
   // one shift offset per line, both step and wrap together
   // seven bits, since a single line runs up to 4Fh
   function [6:0] wrap_shift;
      input [6:0] s;
      input right;
      input two;
      reg [6:0] last;
      begin
         last = two ? `SHIFT_LAST : `ONE_LINE_LAST;
         if (right)
            wrap_shift = (s == 7'h00) ? last : s - 7'h01;
         else
            wrap_shift = (s >= last) ? 7'h00 : s + 7'h01;
      end
   endfunction
   // ==================================================
   // instruction state
   reg [6:0] addr_d;
   reg [6:0] sh1_d;
   reg [6:0] sh2_d;
   reg do_shift;
   reg shift_right;
   always @*
   begin
      addr_d = o_addr_counter;
      do_shift = 1'b0;
      shift_right = 1'b0;
      if (i_addr_load)
         addr_d = i_addr_value;
      else if (is_shf && !dat_s[`SHF_TARGET_BIT])
         addr_d = step_char(o_addr_counter, dat_s[`SHF_DIR_BIT],
            o_two_lines);
      else if (is_shf)
      begin
         do_shift = 1'b1;
         shift_right = dat_s[`SHF_DIR_BIT];
      end
      else if (i_ram_access)
      begin
         case (i_ram_target)
            TGT_CHAR:
            begin
               // the counter steps even on a follow write; the shift
               // is what holds the cursor still on the glass
               addr_d = step_char(o_addr_counter, o_entry_dir,
                  o_two_lines);
               if (o_entry_follow && i_ram_write)
               begin
                  do_shift = 1'b1;
                  shift_right = ~o_entry_dir;
               end
            end
            TGT_GLYPH:
               addr_d = o_entry_dir ? o_addr_counter + 7'h01
                  : o_addr_counter - 7'h01;
            TGT_ARB:
               addr_d = o_entry_dir ? o_addr_counter + 7'h01
                  : o_addr_counter - 7'h01;
            default:
               addr_d = o_addr_counter;
         endcase
      end
      sh1_d = do_shift ? wrap_shift(o_shift_line1, shift_right,
         o_two_lines) : o_shift_line1;
      sh2_d = do_shift ? wrap_shift(o_shift_line2, shift_right,
         o_two_lines) : o_shift_line2;
   end
   reg disp_on_q;
   reg cur_q;
   reg blink_q;
   always @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_addr_counter <= 7'h00;
         o_shift_line1 <= 7'h00;
         o_shift_line2 <= 7'h00;
         o_entry_dir <= `ENT_DIR_RST;
         o_entry_follow <= `ENT_FOLLOW_RST;
         disp_on_q <= 1'b0;
         cur_q <= 1'b0;
         blink_q <= 1'b0;
         o_bus_width_select <= `WIDTH_RST;
         o_two_lines <= 1'b0;
         o_big_font <= 1'b0;
         o_function_done <= 1'b0;
         o_busy_flag <= 1'b0;
         o_show_chars <= 1'b0;
         o_show_cursor <= 1'b0;
         o_show_blink <= 1'b0;
         o_duty <= `DUTY_9;
         o_bias <= `BIAS_4;
         o_commons <= `DUTY_9;
      end
      else
      begin
         o_addr_counter <= addr_d;
         o_shift_line1 <= sh1_d;
         o_shift_line2 <= sh2_d;
         // flag also covers the take cycle, so a poll never sees a gap
         o_busy_flag <= busy | start;
         if (is_ent)
         begin
            o_entry_dir <= dat_s[`ENT_DIR_BIT];
            o_entry_follow <= dat_s[`ENT_FOLLOW_BIT];
         end
         // ram untouched here, only visibility changes
         if (is_disp)
         begin
            disp_on_q <= dat_s[`DISP_ON_BIT];
            cur_q <= dat_s[`DISP_CUR_BIT];
            blink_q <= dat_s[`DISP_BLINK_BIT];
         end
         // visible outputs lag the stored bits by one clock
         o_show_chars <= disp_on_q;
         o_show_cursor <= disp_on_q & cur_q;
         o_show_blink <= disp_on_q & blink_q;
         if (is_fn)
         begin
            if (!ser_s)
               o_bus_width_select <= dat_s[`FN_WIDTH_BIT];
            if (!o_function_done)
            begin
               o_two_lines <= dat_s[`FN_LINES_BIT];
               o_big_font <= dat_s[`FN_FONT_BIT] & ~dat_s[`FN_LINES_BIT];
               o_function_done <= 1'b1;
            end
         end
         // drive table from the latched line and font bits
         case ({o_two_lines, o_big_font})
            2'h0:
            begin
               o_duty <= `DUTY_9;
               o_bias <= `BIAS_4;
               o_commons <= `DUTY_9;
            end
            2'h1:
            begin
               o_duty <= `DUTY_12;
               o_bias <= `BIAS_4;
               o_commons <= `DUTY_12;
            end
            default:
            begin
               o_duty <= `DUTY_17;
               o_bias <= `BIAS_5;
               o_commons <= `DUTY_17;
            end
         endcase
      end
   end
endmodule // lcd_mode_shift_instructions
`default_nettype wire

// [sim/lcd_msi_properties.sv]
// checker for the mode and shift instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "lcd_instr_map.vh"
module lcd_msi_properties
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // ram events
   input wire logic i_ram_access,
   input wire logic i_ram_write,
   input wire logic [1:0] i_ram_target,
   input wire logic i_addr_load,
   // state
   input wire logic o_busy_flag,
   input wire logic [6:0] o_addr_counter,
   input wire logic [6:0] o_shift_line1,
   input wire logic o_entry_dir,
   input wire logic o_entry_follow,
   input wire logic o_show_chars,
   input wire logic o_show_cursor,
   input wire logic o_show_blink,
   input wire logic o_two_lines,
   input wire logic [2:0] o_bias,
   input wire logic o_function_done
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   // ==========================
   // busy length counter
   logic [12:0] busy_cnt_q;
   always_ff @(posedge i_clk or negedge i_reset_n)
      if (!i_reset_n)
         busy_cnt_q <= 13'h0000;
      else
         busy_cnt_q <= o_busy_flag ? busy_cnt_q + 13'h0001 : 13'h0000;
   sequence fn_done_s;
      $rose(o_function_done);
   endsequence
   sequence char_wr_s;
      i_ram_access && i_ram_write && i_ram_target == 2'h0;
   endsequence
   busy_bound_a: assert property (busy_cnt_q <= `EXEC_CYC + 1)
      else $error("busy too long");
   cursor_gate_a: assert property (o_show_cursor
      |-> o_show_chars) else $error("cursor without display");
   blink_gate_a: assert property (o_show_blink
      |-> o_show_chars) else $error("blink without display");
   bias_table_a: assert property (fn_done_s |-> ##[1:4]
      o_bias == (o_two_lines ? `BIAS_5 : `BIAS_4)) else $error("bad bias");
   fn_lock_a: assert property (o_function_done &&
      $past(o_function_done, 4) |-> $stable(o_two_lines))
      else $error("line count changed");
   addr_step_a: assert property (i_ram_access && !i_addr_load &&
      !o_entry_follow && o_addr_counter == 7'h10 |=>
      o_addr_counter == ($past(o_entry_dir) ? 7'h11 : 7'h0F))
      else $error("bad address step");
   follow_write_a: assert property (char_wr_s ##0 o_entry_follow
      |=> o_shift_line1 != $past(o_shift_line1)) else $error("no shift");
   follow_other_a: assert property (i_ram_access
      && o_entry_follow && !(i_ram_write && i_ram_target == 2'h0)
      |=> $stable(o_shift_line1)) else $error("stray shift");
   no_follow_a: assert property (i_ram_access && !o_entry_follow
      |=> $stable(o_shift_line1)) else $error("shift without follow");
endmodule // lcd_msi_properties
bind lcd_mode_shift_instructions lcd_msi_properties lcd_msi_properties_i
(
   .i_clk, .i_reset_n, .i_ram_access, .i_ram_write, .i_ram_target,
   .i_addr_load, .o_busy_flag, .o_addr_counter, .o_shift_line1,
   .o_entry_dir, .o_entry_follow, .o_show_chars, .o_show_cursor,
   .o_show_blink, .o_two_lines, .o_bias, .o_function_done
);
`default_nettype wire

// [sim/lcd_host_model.sv]
// host model writing instructions into the decoder pins
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model
(
   // clock and status
   input wire logic i_clk,
   input wire logic i_busy,
   // instruction pins
   output var logic o_strobe,
   output var logic o_rs_high,
   output var logic o_rs_low,
   output var logic o_rnw,
   output var logic [7:0] o_data
);
   initial
   begin
      o_strobe = 1'b0;
      o_rs_high = 1'b0;
      o_rs_low = 1'b1;
      o_rnw = 1'b1;
      o_data = 8'hA5;
   end
   // one whole byte, held until busy answers or a short wait runs out
   task automatic send(input logic rw, input logic [7:0] d);
      int n;
      n = 0;
      repeat (2) @(posedge i_clk);
      while (i_busy !== 1'b0 && n < 4000)
      begin
         @(posedge i_clk);
         n++;
      end
      o_rs_high <= 1'b1;
      o_rs_low <= 1'b0;
      o_rnw <= rw;
      o_data <= d;
      o_strobe <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (i_busy !== 1'b1 && n < 10);
      o_strobe <= 1'b0;
      o_data <= ~d;
   endtask
endmodule // lcd_host_model
`default_nettype wire

// [sim/lcd_mode_shift_instructions_tb.sv]
// self-checking bench for the mode and shift instruction decoder
`timescale 1ns/1ps
`default_nettype none
module lcd_mode_shift_instructions_tb;
   // ==========================
   // signals and instances
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic acc = 1'b0;
   logic wr = 1'b0;
   logic ld = 1'b0;
   logic ser = 1'b0;
   logic [1:0] tgt = 2'h0;
   logic [6:0] av = 7'h00;
   logic stb, rsh, rsl, rnw, busy, edir, efol, chr, cur, blk, bw, two, big, fd;
   logic [7:0] dat;
   logic [6:0] ac;
   logic [6:0] s1, s2;
   logic [4:0] duty, com;
   logic [2:0] bias;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   lcd_mode_shift_instructions lcd_mode_shift_instructions_i
   (
      .i_clk(clk), .i_reset_n(rst_n), .i_strobe(stb),
      .i_register_select_high(rsh), .i_register_select_low(rsl),
      .i_read_not_write(rnw), .i_data(dat), .i_serial_mode(ser),
      .i_ram_access(acc), .i_ram_write(wr), .i_ram_target(tgt),
      .i_addr_load(ld), .i_addr_value(av), .o_busy_flag(busy),
      .o_addr_counter(ac), .o_shift_line1(s1), .o_shift_line2(s2),
      .o_entry_dir(edir), .o_entry_follow(efol), .o_show_chars(chr),
      .o_show_cursor(cur), .o_show_blink(blk), .o_bus_width_select(bw),
      .o_two_lines(two), .o_big_font(big), .o_duty(duty), .o_bias(bias),
      .o_commons(com), .o_function_done(fd)
   );
   lcd_host_model lcd_host_model_i
   (
      .i_clk(clk), .i_busy(busy), .o_strobe(stb), .o_rs_high(rsh),
      .o_rs_low(rsl), .o_rnw(rnw), .o_data(dat)
   );
   // ==========================
   // shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // instruction, then time for the slower display outputs
   task automatic cmd(input logic [7:0] d);
      lcd_host_model_i.send(1'b0, d);
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   // one ram event or address load
   task automatic ev(input logic l, w, input logic [1:0] t,
                     input logic [6:0] a);
      @(posedge clk);
      acc <= ~l;
      ld <= l;
      wr <= w;
      tgt <= t;
      av <= a;
      @(posedge clk);
      acc <= 1'b0;
      ld <= 1'b0;
      @(negedge clk);
   endtask
   // ==========================
   // scenarios
   task automatic t_func;
      cmd(8'h38);
      chk(8'(busy), 8'h01);
      chk({bias, duty}, 8'hB1);
      chk(8'(com), 8'h11);
      chk(8'({two, big, bw, fd}), 8'h0B);
      lcd_host_model_i.send(1'b1, 8'h20);
      @(negedge clk);
      chk(8'({busy, bw}), 8'h01);
      cmd(8'h20);
      chk(8'({two, bw}), 8'h02);
      @(posedge clk) ser <= 1'b1;
      cmd(8'h30);
      chk(8'(bw), 8'h00);
      @(posedge clk) ser <= 1'b0;
   endtask
   task automatic t_entry;
      cmd(8'h05);
      chk(8'({edir, efol}), 8'h01);
      cmd(8'h06);
      chk(8'({edir, efol}), 8'h02);
      ev(1'b1, 1'b0, 2'h0, 7'h10);
      ev(1'b0, 1'b1, 2'h0, 7'h00);
      chk(8'(ac), 8'h11);
      chk(8'(s1), 8'h00);
      cmd(8'h04);
      ev(1'b0, 1'b0, 2'h1, 7'h00);
      chk(8'(ac), 8'h10);
      ev(1'b0, 1'b1, 2'h2, 7'h00);
      chk(8'(ac), 8'h0F);
      cmd(8'h07);
      ev(1'b0, 1'b1, 2'h0, 7'h00);
      chk(8'(s1), 8'h01);
      ev(1'b0, 1'b0, 2'h0, 7'h00);
      chk(8'(s1), 8'h01);
      chk(8'(ac), 8'h11);
   endtask
   task automatic t_disp;
      logic [2:0] want;
      for (int i = 8; i < 16; i++)
      begin
         cmd(8'(i));
         want = {i[2], i[1] & i[2], i[0] & i[2]};
         chk(8'({chr, cur, blk}), 8'(want));
      end
   endtask
   task automatic t_shift;
      ev(1'b1, 1'b0, 2'h0, 7'h27);
      cmd(8'h14);
      chk(8'(ac), 8'h40);
      cmd(8'h10);
      chk(8'(ac), 8'h27);
      cmd(8'h18);
      chk(8'(s1), 8'h02);
      chk(8'(ac), 8'h27);
      chk(8'(s2), 8'h02);
      cmd(8'h1C);
      chk(8'(s1), 8'h01);
      chk(8'(ac), 8'h27);
      repeat (39) ev(1'b0, 1'b1, 2'h0, 7'h00);
      chk(8'(s1), 8'h00);
      chk(8'(s2), 8'h00);
      chk(8'(ac), 8'h66);
   endtask
   // second reset, then the one-line large font
   task automatic t_font;
      @(posedge clk) rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      cmd(8'h24);
      chk({bias, duty}, 8'h8C);
      chk(8'(com), 8'h0C);
      chk(8'({two, big, bw, fd}), 8'h05);
      ev(1'b1, 1'b0, 2'h0, 7'h4F);
      ev(1'b0, 1'b1, 2'h0, 7'h00);
      chk(8'(ac), 8'h00);
      cmd(8'h1C);
      chk(8'(s1), 8'h4F);
   endtask
   // ==========================
   // main sequence and hang guard
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_func;
      t_entry;
      t_disp;
      t_shift;
      t_font;
      end_sim;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         err_count++;
         end_sim;
      end
   end
endmodule // lcd_mode_shift_instructions_tb
`default_nettype wire
